// *** rtl/sid_spi_port.sv ***
// serial port: interrupts, rate divider, shift data and control registers
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
// How it works
// [RULE1] request raised after every finished character
// [RULE2] character length one to eight bits
// [RULE3] peripheral raises per character, select held low
// [RULE4] peripheral select release mid-character raises event
// [RULE5] writing one clears pending flag, withdraws request
// [RULE6] software must clear pending for further requests
// [RULE7] force bit sets pending; clear returns it
// [RULE8] disabled port with timer enable interrupts
// [RULE9] timer time-out leaves pending flag alone
// [RULE10] divider counts clocks with 16-bit reload
// [RULE11] bit rate is clock over twice reload
// [RULE12] zero reload acts as 65536
// [RULE13] timer period equals reload clock periods
// [RULE14] data read shows shift register, msb first
// [RULE15] controller write starts; peripheral write preloads
// [RULE16] write during transfer discarded, sets overrun
// [RULE17] transmit left justified, receive right justified
// [RULE18] enable bit seven gates all requests
// [RULE19] timer enable ignored while port enabled
// [RULE20] bit four phase, bit three idle level
// [RULE21] bit two makes all pins open-drain
// [RULE22] bit one controller mode, bit zero enable
// [RULE23] phase and polarity choose drive/sample edges
// [RULE24] abort sets flags; restart from bit seven
// [RULE25] request on pending set or timer time-out
module sid_spi_port
   import sid_pkg::*;
(
   input wire logic sys_clk_in,             // system clock, 10 MHz
   input wire logic resetn_in,              // asynchronous reset, active low
   input wire logic clk_en_in,              // freezes all state while low
   input wire logic axi_awvalid_in,         // write address valid
   output logic axi_awready_out,            // write address ready
   input wire logic [15:0] axi_awaddr_in,   // write byte address
   input wire logic axi_wvalid_in,          // write data valid
   output logic axi_wready_out,             // write data ready
   input wire logic [31:0] axi_wdata_in,    // write data
   input wire logic [3:0] axi_wstrb_in,     // write byte strobes
   output logic axi_bvalid_out,             // write response valid
   input wire logic axi_bready_in,          // write response ready
   output logic [1:0] axi_bresp_out,        // write response code
   input wire logic axi_arvalid_in,         // read address valid
   output logic axi_arready_out,            // read address ready
   input wire logic [15:0] axi_araddr_in,   // read byte address
   output logic axi_rvalid_out,             // read data valid
   input wire logic axi_rready_in,          // read data ready
   output logic [31:0] axi_rdata_out,       // read data
   output logic [1:0] axi_rresp_out,        // read response code
   input wire logic sck_in,                 // serial clock pin level
   output logic sck_out,                    // serial clock drive value
   output logic sck_oe_out,                 // serial clock drive enable
   input wire logic ss_n_in,                // select pin level, active low
   output logic ss_n_out,                   // select drive value
   output logic ss_n_oe_out,                // select drive enable
   input wire logic miso_in,                // peripheral-to-controller pin level
   output logic miso_out,                   // its drive value
   output logic miso_oe_out,                // its drive enable
   input wire logic mosi_in,                // controller-to-peripheral pin level
   output logic mosi_out,                   // its drive value
   output logic mosi_oe_out,                // its drive enable
   output logic irq_req_out                 // one-cycle request to interrupt controller
);

   sid_state_type st;        // registered state
   sid_state_type next_st;   // next state

   // decoded control fields
   logic en, ctlr, phase, pol, od, ie;
   logic [3:0] len;          // character length in bits
   logic [15:0] reload_m1;   // reload minus one, wraps zero to 65535
   logic div_tick;           // divider reached its end
   logic tmr_fire;           // general timer time-out
   logic wr_go, wr_hit, rd_hit;
   logic wr_data, wr_ctrl, wr_stat, wr_fmt, wr_div;
   logic ctl_start;          // controller transfer starts
   logic [31:0] rd_word;     // read mux
   logic sel, sck_edge, lead;
   logic p_sample, p_tx, abort;
   logic [4:0] c_edge;       // index of the clock edge about to happen
   logic c_sample, c_tx, c_last;
   logic sample_bit;
   logic [SID_NPINS-1:0] pin_lvl, pin_drv, pin_out, pin_oe;

   assign en = st.ctrl[SID_EN_BIT];          // see [RULE22]
   assign ctlr = st.ctrl[SID_CTLR_BIT];      // see [RULE22]
   assign phase = st.ctrl[SID_PHASE_BIT];    // see [RULE20]
   assign pol = st.ctrl[SID_POL_BIT];        // see [RULE20]
   assign od = st.ctrl[SID_OD_BIT];
   assign ie = st.ctrl[SID_IE_BIT];
   // zero in the field stands for a full byte
   assign len = (st.fmt_len == 3'h0) ? SID_FULL_CHAR : {1'b0, st.fmt_len}; // see [RULE2]
   // zero reload minus one gives 65535, so the count lasts 65536 clocks
   assign reload_m1 = st.div - 16'h0001;     // see [RULE12]
   assign div_tick = (st.div_cnt == 16'h0000);
   // timer enable only matters with the port off
   assign tmr_fire = ~en & st.ctrl[SID_TIMER_BIT] & div_tick; // see [RULE19]

   // bus decode: a write completes once both address and data are held
   assign wr_go = st.aw_ok & st.w_ok & ~st.bvalid;
   assign wr_data = wr_go & st.w_strb[0] & (st.aw_addr == SID_DATA_ADDR);
   assign wr_ctrl = wr_go & st.w_strb[0] & (st.aw_addr == SID_CTRL_ADDR);
   assign wr_stat = wr_go & st.w_strb[0] & (st.aw_addr == SID_STAT_ADDR);
   assign wr_fmt = wr_go & st.w_strb[0] & (st.aw_addr == SID_FMT_ADDR);
   assign wr_div = wr_go & (st.aw_addr == SID_DIV_ADDR);
   assign wr_hit = (st.aw_addr == SID_DATA_ADDR) | (st.aw_addr == SID_CTRL_ADDR) |
                   (st.aw_addr == SID_STAT_ADDR) | (st.aw_addr == SID_FMT_ADDR) |
                   (st.aw_addr == SID_DIV_ADDR);
   assign ctl_start = wr_data & ~st.busy & en & ctlr; // see [RULE15]

   // peripheral side: pins are synchronous, so edges come from one stored sample
   assign sel = ~ss_n_in;
   assign sck_edge = (sck_in != st.sck_prev);
   assign lead = (st.sck_prev == pol);       // clock leaving its idle level
   // phase 0 samples on the leading edge, phase 1 on the trailing one
   assign p_sample = en & ~ctlr & sel & sck_edge & (lead ^ phase);  // see [RULE23]
   assign p_tx = en & ~ctlr & sel & sck_edge & ~(lead ^ phase);     // see [RULE23]
   // select released while a character is only partly moved
   assign abort = en & ~ctlr & st.busy & ss_n_in & ~st.ss_prev_n; // see [RULE4]

   // controller side: odd edges lead, even edges trail
   assign c_edge = 5'(st.cnt + 5'h01);
   assign c_sample = en & ctlr & st.busy & div_tick & (c_edge[0] ^ phase); // see [RULE23]
   assign c_tx = en & ctlr & st.busy & div_tick & ~(c_edge[0] ^ phase);
   assign c_last = (c_edge == {len, 1'b0});
   assign sample_bit = ctlr ? miso_in : mosi_in;

   // read mux, reserved bits read as zero
   always_comb begin
      rd_hit = 1'b1;
      rd_word = 32'h0000_0000;
      if (axi_araddr_in == SID_DATA_ADDR) begin
         rd_word = {24'h00_0000, st.sr};  // see [RULE14]
      end else if (axi_araddr_in == SID_CTRL_ADDR) begin
         rd_word = {24'h00_0000, st.ctrl};
      end else if (axi_araddr_in == SID_STAT_ADDR) begin
         rd_word[SID_PEND_BIT] = st.pend;
         rd_word[SID_OVR_BIT] = st.write_overrun_flag;
         rd_word[SID_ABT_BIT] = st.early_end_flag;
         rd_word[SID_BUSY_BIT] = st.busy;
         rd_word[SID_SEL_BIT] = ss_n_in;
      end else if (axi_araddr_in == SID_FMT_ADDR) begin
         rd_word[SID_LEN_LSB +: 3] = st.fmt_len;
      end else if (axi_araddr_in == SID_DIV_ADDR) begin
         rd_word = {16'h0000, st.div};
      end else begin
         rd_hit = 1'b0;   // unmapped: slave error, zero data
      end
   end

   // next-state logic: bus first, then register effects, engine last so its sets win
   always_comb begin
      next_st = st;
      next_st.sck_prev = sck_in;
      next_st.ss_prev_n = ss_n_in;
      // write address and data are taken independently
      if (axi_awvalid_in & axi_awready_out) begin
         next_st.aw_ok = 1'b1;
         next_st.aw_addr = axi_awaddr_in;
      end
      if (axi_wvalid_in & axi_wready_out) begin
         next_st.w_ok = 1'b1;
         next_st.w_data = axi_wdata_in;
         next_st.w_strb = axi_wstrb_in;
      end
      if (st.bvalid & axi_bready_in) begin
         next_st.bvalid = 1'b0;
      end
      if (wr_go) begin
         next_st.aw_ok = 1'b0;
         next_st.w_ok = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = wr_hit ? SID_RESP_OKAY : SID_RESP_SLVERR;
      end
      // read answer registered on the same edge that takes the address
      if (axi_arvalid_in & axi_arready_out) begin
         next_st.rvalid = 1'b1;
         next_st.rdata = rd_word;
         next_st.rresp = rd_hit ? SID_RESP_OKAY : SID_RESP_SLVERR;
      end else if (st.rvalid & axi_rready_in) begin
         next_st.rvalid = 1'b0;
      end
      // register writes
      if (wr_ctrl) begin
         next_st.ctrl = st.w_data[7:0];
         // the force bit is sticky until the pending flag is cleared
         next_st.ctrl[SID_FORCE_BIT] = st.ctrl[SID_FORCE_BIT] | st.w_data[SID_FORCE_BIT];
         if (st.w_data[SID_FORCE_BIT] & st.w_data[SID_EN_BIT]) begin
            next_st.pend = 1'b1;  // see [RULE7]
         end
      end
      if (wr_stat) begin
         if (st.w_data[SID_PEND_BIT]) begin
            next_st.pend = 1'b0;                 // see [RULE5]
            next_st.ctrl[SID_FORCE_BIT] = 1'b0;  // see [RULE7]
         end
         if (st.w_data[SID_OVR_BIT]) begin
            next_st.write_overrun_flag = 1'b0;
         end
         if (st.w_data[SID_ABT_BIT]) begin
            next_st.early_end_flag = 1'b0;
         end
      end
      if (wr_fmt) begin
         next_st.fmt_len = st.w_data[SID_LEN_LSB +: 3];
      end
      // the divider takes two byte lanes
      if (wr_div & st.w_strb[0]) begin
         next_st.div[7:0] = st.w_data[7:0];     // see [RULE10]
      end
      if (wr_div & st.w_strb[1]) begin
         next_st.div[15:8] = st.w_data[15:8];   // see [RULE10]
      end
      if (wr_data) begin
         if (st.busy) begin
            next_st.write_overrun_flag = 1'b1;   // data kept as it was, see [RULE16]
         end else begin
            next_st.sr = st.w_data[7:0];  // peripheral just preloads, see [RULE15]
         end
      end
      if (ctl_start) begin
         next_st.busy = 1'b1;
         next_st.cnt = 5'h00;
         next_st.div_cnt = reload_m1;
         next_st.sck_lvl = pol;
         if (!phase) begin
            next_st.tx_bit = st.w_data[7];  // phase 0 shows bit 7 before the first edge
         end
      end
      // engine
      if (!en) begin
         // flags hold reset values while off; a write that enables with force keeps its set
         next_st.busy = 1'b0;
         next_st.cnt = 5'h00;
         if (!next_st.ctrl[SID_EN_BIT]) begin
            next_st.pend = 1'b0;
            next_st.write_overrun_flag = 1'b0;
            next_st.early_end_flag = 1'b0;
         end
         next_st.sck_lvl = pol;
         // general timer: period of reload clocks, pending flag untouched
         if (st.ctrl[SID_TIMER_BIT] && !div_tick) begin
            next_st.div_cnt = 16'(st.div_cnt - 16'h0001);  // see [RULE13]
         end else begin
            next_st.div_cnt = reload_m1;  // see [RULE8]
         end
      end else if (ctlr) begin
         if (st.busy) begin
            if (div_tick) begin
               // each half bit lasts reload clocks, so a bit takes twice that
               next_st.div_cnt = reload_m1;     // see [RULE11]
               next_st.sck_lvl = ~st.sck_lvl;
               next_st.cnt = c_edge;
               if (c_sample) begin
                  // received bits enter at bit 0, see [RULE17]
                  next_st.sr = {st.sr[6:0], sample_bit};  // see [RULE14]
               end
               if (c_tx) begin
                  next_st.tx_bit = st.sr[7];
               end
               if (c_last) begin
                  next_st.busy = 1'b0;
                  next_st.cnt = 5'h00;
                  next_st.pend = 1'b1;  // see [RULE1]
               end
            end else begin
               next_st.div_cnt = 16'(st.div_cnt - 16'h0001);  // see [RULE10]
            end
         end else if (!ctl_start) begin
            next_st.sck_lvl = pol;  // idle level, see [RULE20]
         end
      end else begin
         next_st.sck_lvl = pol;
         if (abort) begin
            // next select presents bit 7 again through the idle preset
            next_st.early_end_flag = 1'b1;    // see [RULE24]
            next_st.pend = 1'b1;   // see [RULE4]
            next_st.busy = 1'b0;
            next_st.cnt = 5'h00;
         end else begin
            // busy only from the first sampled bit, so the trailing edge after a
            // finished character cannot turn a clean release into an abort
            if (p_sample) begin
               next_st.busy = 1'b1;  // see [RULE4]
            end
            if (p_tx || !st.busy) begin
               next_st.tx_bit = st.sr[7];  // see [RULE24]
            end
            if (p_sample) begin
               next_st.sr = {st.sr[6:0], mosi_in};  // see [RULE17]
               next_st.cnt = c_edge;
               // select may stay low; counting restarts each character
               if (c_edge == {1'b0, len}) begin
                  next_st.busy = 1'b0;
                  next_st.cnt = 5'h00;
                  next_st.pend = 1'b1;  // see [RULE3]
               end
            end
         end
      end
      // request pulse: a fresh pending flag or a timer time-out, gated by enable
      next_st.irq = ie & ((next_st.pend & ~st.pend) | tmr_fire);  // see [RULE25] [RULE18] [RULE9]
   end

   // single state register; clock enable freezes everything
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st <= SID_STATE_RST;
      end else if (clk_en_in) begin
         st <= next_st;
      end
   end

   // pin drive: controller owns clock, select, data out; peripheral owns miso when selected
   assign pin_lvl[SID_PIN_SCK] = st.sck_lvl;
   assign pin_drv[SID_PIN_SCK] = en & ctlr;
   assign pin_lvl[SID_PIN_SS] = ~st.busy;
   assign pin_drv[SID_PIN_SS] = en & ctlr;
   assign pin_lvl[SID_PIN_MISO] = st.tx_bit;
   assign pin_drv[SID_PIN_MISO] = en & ~ctlr & sel;
   assign pin_lvl[SID_PIN_MOSI] = st.tx_bit;
   assign pin_drv[SID_PIN_MOSI] = en & ctlr;

   // open-drain only pulls low; a high is left to the pull-up
   genvar gi;
   generate
      for (gi = 0; gi < SID_NPINS; gi++) begin : g_pin
         assign pin_out[gi] = od ? 1'b0 : pin_lvl[gi];                  // see [RULE21]
         assign pin_oe[gi] = pin_drv[gi] & (~od | ~pin_lvl[gi]);       // see [RULE21]
      end
   endgenerate

   assign sck_out = pin_out[SID_PIN_SCK];
   assign sck_oe_out = pin_oe[SID_PIN_SCK];
   assign ss_n_out = pin_out[SID_PIN_SS];
   assign ss_n_oe_out = pin_oe[SID_PIN_SS];
   assign miso_out = pin_out[SID_PIN_MISO];
   assign miso_oe_out = pin_oe[SID_PIN_MISO];
   assign mosi_out = pin_out[SID_PIN_MOSI];
   assign mosi_oe_out = pin_oe[SID_PIN_MOSI];

   // bus handshakes; one write and one read held at a time
   assign axi_awready_out = ~st.aw_ok & ~st.bvalid;
   assign axi_wready_out = ~st.w_ok & ~st.bvalid;
   assign axi_bvalid_out = st.bvalid;
   assign axi_bresp_out = st.bresp;
   assign axi_arready_out = ~st.rvalid;
   assign axi_rvalid_out = st.rvalid;
   assign axi_rdata_out = st.rdata;
   assign axi_rresp_out = st.rresp;
   assign irq_req_out = st.irq;

   // checks on the design's own behaviour
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);

   sequence s_ctl_start;
      clk_en_in && ctl_start;
   endsequence
   sequence s_abort;
      clk_en_in && abort;
   endsequence
   sequence s_fresh_pend;
      clk_en_in && ie && next_st.pend && !st.pend;
   endsequence

   done_irq_a: assert property (s_fresh_pend |=> irq_req_out) // see [RULE1]
      else $error("fresh pending flag gave no request");
   pend_clear_a: assert property (clk_en_in && wr_stat && st.w_data[SID_PEND_BIT] && ctlr
      && !st.busy && !wr_ctrl |=> !st.pend && !st.ctrl[SID_FORCE_BIT]) // see [RULE5]
      else $error("pending flag or force bit survived clear");
   force_set_a: assert property (clk_en_in && wr_ctrl && st.w_data[SID_FORCE_BIT]
      && st.w_data[SID_EN_BIT] |=> st.pend && st.ctrl[SID_FORCE_BIT]) // see [RULE7]
      else $error("force bit did not set pending");
   timer_only_a: assert property (clk_en_in && tmr_fire && ie
      |=> irq_req_out && !st.pend) // see [RULE9]
      else $error("timer time-out misbehaved");
   overrun_set_a: assert property (clk_en_in && wr_data && st.busy && en
      |=> st.write_overrun_flag) // see [RULE16]
      else $error("write during transfer did not flag overrun");
   ctl_start_a: assert property (s_ctl_start |=> st.busy && st.cnt == 5'h00) // see [RULE15]
      else $error("controller write did not start");
   half_period_a: assert property (clk_en_in && en && ctlr && st.busy && !div_tick
      |=> $stable(st.sck_lvl)) // see [RULE11]
      else $error("serial clock moved before divider end");
   gate_off_a: assert property (!ie |=> !irq_req_out) // see [RULE18]
      else $error("request passed with enable low");
   abort_flags_a: assert property (s_abort |=> st.early_end_flag && st.pend && !st.busy) // see [RULE24]
      else $error("abort did not set flags");
   idle_level_a: assert property (clk_en_in && !st.busy && !ctl_start
      |=> st.sck_lvl == $past(pol)) // see [RULE20]
      else $error("serial clock not at idle level");

endmodule // sid_spi_port

// *** include/sid_pkg.sv ***
// shared constants and the state type of the serial port with rate divider
package sid_pkg;
   // register indices; byte address is four times the index
   localparam logic [13:0] SID_DATA_IDX = 14'h0f60;
   localparam logic [13:0] SID_CTRL_IDX = 14'h0f61;
   localparam logic [13:0] SID_STAT_IDX = 14'h0f62;
   localparam logic [13:0] SID_FMT_IDX = 14'h0f63;
   localparam logic [13:0] SID_DIV_IDX = 14'h0f64;
   localparam logic [15:0] SID_DATA_ADDR = {SID_DATA_IDX, 2'h0};
   localparam logic [15:0] SID_CTRL_ADDR = {SID_CTRL_IDX, 2'h0};
   localparam logic [15:0] SID_STAT_ADDR = {SID_STAT_IDX, 2'h0};
   localparam logic [15:0] SID_FMT_ADDR = {SID_FMT_IDX, 2'h0};
   localparam logic [15:0] SID_DIV_ADDR = {SID_DIV_IDX, 2'h0};
   // control register fields
   localparam int SID_IE_BIT = 7;
   localparam int SID_FORCE_BIT = 6;
   localparam int SID_TIMER_BIT = 5;
   localparam int SID_PHASE_BIT = 4;
   localparam int SID_POL_BIT = 3;
   localparam int SID_OD_BIT = 2;
   localparam int SID_CTLR_BIT = 1;
   localparam int SID_EN_BIT = 0;
   // status register fields
   localparam int SID_PEND_BIT = 7;
   localparam int SID_OVR_BIT = 6;
   localparam int SID_ABT_BIT = 4;
   localparam int SID_BUSY_BIT = 1;
   localparam int SID_SEL_BIT = 0;
   // format register: character length field position
   localparam int SID_LEN_LSB = 2;
   localparam logic [3:0] SID_FULL_CHAR = 4'h8;
   // bus responses
   localparam logic [1:0] SID_RESP_OKAY = 2'h0;
   localparam logic [1:0] SID_RESP_SLVERR = 2'h2;
   // pin slots of the open-drain generate loop
   localparam int SID_NPINS = 4;
   localparam int SID_PIN_SCK = 0;
   localparam int SID_PIN_SS = 1;
   localparam int SID_PIN_MISO = 2;
   localparam int SID_PIN_MOSI = 3;

   // whole state of the port
   typedef struct packed {
      logic [7:0] ctrl;        // port_control_reg
      logic [2:0] fmt_len;     // char_length_field, 0 means eight
      logic [15:0] div;        // rate_divider reload value
      logic [7:0] sr;          // shift_data_reg
      logic pend;              // pending-event flag
      logic write_overrun_flag;               // write_overrun_flag
      logic early_end_flag;               // early_end_flag
      logic busy;              // transfer in progress
      logic [4:0] cnt;         // edges (controller) or bits (peripheral)
      logic [15:0] div_cnt;    // rate divider down counter
      logic sck_lvl;           // driven serial clock level
      logic tx_bit;            // bit presented on the data out pin
      logic sck_prev;          // last sampled clock pin
      logic ss_prev_n;         // last sampled select pin
      logic irq;               // request pulse to interrupt controller
      logic aw_ok;
      logic [15:0] aw_addr;
      logic w_ok;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } sid_state_type;

   localparam sid_state_type SID_STATE_RST = '{ss_prev_n: 1'b1, default: '0};
endpackage

// *** tb/sid_periph_model.sv ***
// far-side serial peripheral model, clock phase 0 and idle low
`timescale 1ns/1ps
module sid_periph_model #(parameter logic [7:0] REPLY = 8'ha5) (
   input wire logic sck_in, // serial clock from the port
   input wire logic ss_n_in, // select, active low
   input wire logic mosi_in, // data from the controller
   output logic miso_out, // data to the controller
   output logic [7:0] got_out // bits received, last in bit 0
);
   logic [7:0] tx; // bits still to send, msb leads
   // reload on select so every frame starts from the top bit
   always @(negedge ss_n_in) tx = REPLY;
   // sample on the rising edge, shift on the falling one
   always @(posedge sck_in) if (!ss_n_in) got_out = {got_out[6:0], mosi_in};
   always @(negedge sck_in) if (!ss_n_in) tx = {tx[6:0], 1'b0};
   // a released line must not keep the last bit, so show its inverse
   always_comb miso_out = ss_n_in ? ~tx[7] : tx[7];
endmodule // sid_periph_model

// *** tb/tb.sv ***
// register-level testbench of the serial port
`timescale 1ns/1ps
module tb;
   import sid_pkg::*;
   logic clk, rstn, awv, wv, br, arv, rr, awr, wr_, bv, arr, rv; // bus handshakes
   logic [15:0] awa, ara; // byte addresses
   logic [31:0] wd, rdat, d; // write, read and scratch data
   logic [1:0] bresp, rresp, r; // response codes
   logic sck_o, sck_oe, ss_o, ss_oe, mi_o, mi_oe, mo_o, mo_oe, irq, pmiso; // pins
   logic [7:0] got; // what the peripheral received
   logic tsck = 1'b0, tss = 1'b1, tmo = 1'b0; // bench as far-side controller
   logic [7:0] pm; // bits seen on miso by the bench
   int mismatches = 0, samples_checked = 0, irqs, ssl, cyc = 0;
   wire sck = sck_oe ? sck_o : tsck; // bench clock when released, idles low
   wire ss = ss_oe ? ss_o : tss; // bench select when released, idles high
   wire miso = mi_oe ? mi_o : pmiso;
   wire mosi = mo_oe ? mo_o : tmo;
   sid_spi_port i_sid_spi_port (.sys_clk_in(clk), .resetn_in(rstn), .clk_en_in(1'b1),
      .axi_awvalid_in(awv), .axi_awready_out(awr), .axi_awaddr_in(awa), .axi_wvalid_in(wv),
      .axi_wready_out(wr_), .axi_wdata_in(wd), .axi_wstrb_in(4'hf), .axi_bvalid_out(bv),
      .axi_bready_in(br), .axi_bresp_out(bresp), .axi_arvalid_in(arv), .axi_arready_out(arr),
      .axi_araddr_in(ara), .axi_rvalid_out(rv), .axi_rready_in(rr), .axi_rdata_out(rdat),
      .axi_rresp_out(rresp), .sck_in(sck), .sck_out(sck_o), .sck_oe_out(sck_oe), .ss_n_in(ss),
      .ss_n_out(ss_o), .ss_n_oe_out(ss_oe), .miso_in(miso), .miso_out(mi_o),
      .miso_oe_out(mi_oe), .mosi_in(mosi), .mosi_out(mo_o), .mosi_oe_out(mo_oe),
      .irq_req_out(irq));
   sid_periph_model i_sid_periph_model (.sck_in(sck), .ss_n_in(ss), .mosi_in(mosi),
      .miso_out(pmiso), .got_out(got));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // count pulses and select-low cycles away from the rising edge
   always @(negedge clk) begin
      if (irq === 1'b1) irqs++;
      if (ss === 1'b0) ssl++;
   end
   // hang guard, far above the several hundred cycles the tests need
   always @(posedge clk) if (++cyc == 20000) begin
      mismatches++;
      give_verdict();
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // ready is looked at mid-cycle, where it is settled for the next edge
   task automatic wrr(input logic [15:0] a, input logic [31:0] dv);
      logic ta, tw;
      awa <= a; wd <= dv; awv <= 1'b1; wv <= 1'b1;
      do begin
         @(negedge clk);
         ta = awv & awr;
         tw = wv & wr_;
         @(posedge clk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
      end while (!(ta && tw) && (awv || wv));
      br <= 1'b1;
      do @(negedge clk); while (bv !== 1'b1);
      @(posedge clk) br <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [31:0] dv, output logic [1:0] rs);
      ara <= a; arv <= 1'b1;
      do @(negedge clk); while (arr !== 1'b1);
      @(posedge clk) arv <= 1'b0;
      rr <= 1'b1;
      do @(negedge clk); while (rv !== 1'b1);
      dv = rdat;
      rs = rresp;
      @(posedge clk) rr <= 1'b0;
   endtask
   task automatic rc(input logic [15:0] a, input logic [31:0] e);
      rd(a, d, r);
      chk(d, e);
   endtask
   // n bits of c, msb first, as far-side controller in phase 0, eight clocks a bit;
   // miso is taken just before each rising edge, where it has long settled
   task automatic pch(input logic [3:0] c, input int n);
      for (int i = 3; i > 3 - n; i--) begin
         tmo <= c[i];
         repeat (4) @(posedge clk);
         pm = {pm[6:0], miso};
         tsck <= 1'b1;
         repeat (4) @(posedge clk);
         tsck <= 1'b0;
      end
   endtask
   // poll busy in the status register until the frame is over
   task automatic idle();
      do rd(SID_STAT_ADDR, d, r); while (d[SID_BUSY_BIT] === 1'b1);
      repeat (3) @(posedge clk);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      {awv, wv, br, arv, rr, awa, ara, wd} = '0;
      rstn = 1'b0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rc(SID_CTRL_ADDR, 32'h0);
      rd(16'h0100, d, r);
      chk(r, SID_RESP_SLVERR);
      $display("test reset done");
      wrr(SID_DIV_ADDR, 32'h2);
      wrr(SID_CTRL_ADDR, 32'h83);
      irqs = 0;
      ssl = 0;
      wrr(SID_DATA_ADDR, 32'h3c);
      idle();
      chk(ssl, 32);
      chk(irqs, 1);
      chk(got, 8'h3c);
      rc(SID_DATA_ADDR, 32'ha5);
      rc(SID_STAT_ADDR, 32'h81);
      wrr(SID_STAT_ADDR, 32'hd0);
      rc(SID_STAT_ADDR, 32'h01);
      wrr(SID_DATA_ADDR, 32'h3c);
      wrr(SID_DATA_ADDR, 32'h00);
      idle();
      rc(SID_DATA_ADDR, 32'ha5);
      rc(SID_STAT_ADDR, 32'hc1);
      wrr(SID_STAT_ADDR, 32'hd0);
      $display("test controller done");
      wrr(SID_FMT_ADDR, 32'h10);
      wrr(SID_DATA_ADDR, 32'ha0);
      idle();
      rc(SID_DATA_ADDR, 32'h0a);
      chk(got[3:0], 4'ha);
      wrr(SID_STAT_ADDR, 32'hd0);
      irqs = 0;
      wrr(SID_CTRL_ADDR, 32'hc3);
      rc(SID_STAT_ADDR, 32'h81);
      chk(irqs, 1);
      wrr(SID_STAT_ADDR, 32'h80);
      rc(SID_CTRL_ADDR, 32'h83);
      $display("test length and force done");
      wrr(SID_CTRL_ADDR, 32'h0);
      wrr(SID_DIV_ADDR, 32'h5);
      wrr(SID_CTRL_ADDR, 32'ha0);
      irqs = 0;
      repeat (50) @(posedge clk);
      chk(irqs, 10);
      rc(SID_STAT_ADDR, 32'h01);
      wrr(SID_CTRL_ADDR, 32'h20);
      irqs = 0;
      repeat (50) @(posedge clk);
      chk(irqs, 0);
      wrr(SID_CTRL_ADDR, 32'ha1);
      irqs = 0;
      repeat (50) @(posedge clk);
      chk(irqs, 0);
      $display("test timer done");
      // peripheral, four-bit characters, select held low across two of them
      wrr(SID_DATA_ADDR, 32'h90);
      irqs = 0;
      tss <= 1'b0;
      pch(4'hb, 4);
      rc(SID_STAT_ADDR, 32'h80);
      wrr(SID_STAT_ADDR, 32'h80);
      pch(4'h6, 4);
      chk(pm, 8'h90);
      rc(SID_DATA_ADDR, 32'hb6);
      wrr(SID_STAT_ADDR, 32'h80);
      pch(4'hc, 2);
      tss <= 1'b1;
      repeat (3) @(posedge clk);
      rc(SID_STAT_ADDR, 32'h91);
      chk(irqs, 3);
      wrr(SID_STAT_ADDR, 32'hd0);
      tss <= 1'b0;
      pch(4'h3, 4);
      tss <= 1'b1;
      repeat (3) @(posedge clk);
      rc(SID_STAT_ADDR, 32'h81);
      $display("test peripheral done");
      give_verdict();
   end
endmodule // tb
